// [src/priority_interrupt_controller.sv]
/*
 * Priority interrupt controller: request flags, enables and per-source
 * levels; arbitration against the CPU level with nesting and timed
 * disable; vector fetch from the primary or alternate table and the
 * program-counter load multiplexer; address error trap on fetches or
 * jumps into vector space.
 * Assumes peripherals deliver one-cycle request pulses on clk, the core
 * drives the acceptance, return and instruction-retire strobes on clk,
 * and only external pins are asynchronous.
 */
`timescale 1ns/1ps
module priority_interrupt_controller #(
   parameter int          NUM_SRC  = intc_pkg::NUM_SRC_DEF,
   parameter int          TIMED_DISABLE_W   = intc_pkg::TIMED_DISABLE_W_DEF,
   parameter logic [23:0] ALT_BASE = intc_pkg::ALT_BASE_DEF
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        srst,
   // Avalon-MM register slave
   input  wire logic [intc_pkg::ADDR_W-1:0] address,
   input  wire logic                        read,
   input  wire logic                        write,
   input  wire logic [31:0]                 writedata,
   input  wire logic [3:0]                  byteenable,
   output logic      [31:0]                 readdata,
   output logic                             waitrequest,
   // Request sources
   input  wire logic [NUM_SRC-1:0]          srcEvent,
   input  wire logic [intc_pkg::NUM_EXT-1:0] extPin,
   input  wire logic [intc_pkg::NUM_TRAP-1:0] trapEvent,
   // Core acceptance and return
   output logic                             irqReq,
   output logic      [3:0]                  irqLevel,
   output logic      [23:0]                 irqVecAddr,
   input  wire logic                        irqAck,
   input  wire logic                        retDone,
   input  wire logic [3:0]                  retLevel,
   output logic      [3:0]                  cpuLevel,
   // Timed disable
   input  wire logic                        disiStart,
   input  wire logic [TIMED_DISABLE_W-1:0]           disiCount,
   input  wire logic                        instrRetire,
   output logic                             timedDisable,
   // Vector fetch over the program bus
   output logic                             vecFetchReq,
   output logic      [23:0]                 vecFetchAddr,
   input  wire logic                        vecFetchValid,
   input  wire logic [23:0]                 progData,
   // Instruction fetch watch and counter load
   input  wire logic                        fetchValid,
   input  wire logic [23:0]                 fetchAddr,
   input  wire logic                        branchValid,
   input  wire logic [23:0]                 branchTarget,
   output logic                             pcLoad,
   output logic      [23:0]                 pcValue
);
   import intc_pkg::*;

   // Refuse sizes the map or the vector numbering cannot hold
   if (NUM_SRC < EXT_SRC_2 + 1 || NUM_SRC > MAX_SRC ||
       NUM_SRC + SRC_VEC_BASE > NUM_VECTORS || TIMED_DISABLE_W < 1 || TIMED_DISABLE_W > 16) begin
      $error("priority_interrupt_controller: unsupported parameters");
   end

   // All state of the block
   typedef struct packed {
      logic [NUM_EXT-1:0]        sync1;      // First synchroniser stage
      logic [NUM_EXT-1:0]        sync2;      // Second synchroniser stage
      logic [NUM_EXT-1:0]        extPrev;    // Previous synchronised level
      logic [NUM_EXT-1:0]        extPol;     // 1 = falling edge requests
      logic [NUM_SRC-1:0]        flags;      // Request flags
      logic [NUM_SRC-1:0]        enables;    // Source enables
      logic [NUM_SRC-1:0][2:0]   prio;       // Per-source level
      logic [NUM_TRAP-1:0]       trapFlags;  // Sticky trap status
      logic                      nestDis;    // Nesting disable
      logic                      altSel;     // Alternate table select
      logic [3:0]                cpuLevel;   // Current CPU level
      logic [3:0]                depth;      // Handlers in service
      logic [TIMED_DISABLE_W-1:0]         disiCnt;    // Instructions left disabled
      ctl_state_t                st;         // Acceptance sequence
      logic [3:0]                offerLevel; // Level shown to the core
      logic [23:0]               offerAddr;  // Vector entry shown to the core
      logic                      pcLoad;     // Counter load strobe
      logic [23:0]               pcValue;    // Counter load value
      logic                      busDone;    // Second cycle of an access
      logic [31:0]               rdata;      // Read data
   } ctl_t;

   ctl_t ctl_r;                              // Registered state
   ctl_t ctl_nxt;                            // Next state

   // Vector space covers both tables
   function automatic logic inVecSpace(input logic [23:0] a);
      return (a >= VEC_FIRST_ADDR) && (a <= VEC_LAST_ADDR ||
             (a >= ALT_BASE && a <= 24'(ALT_BASE + VEC_TABLE_SPAN)));
   endfunction

   // Entry address of a vector number in the selected table
   function automatic logic [23:0] vecEntry(input logic alt, input logic [5:0] vec);
      logic [23:0] base;
      base = alt ? ALT_BASE : VEC_FIRST_ADDR;
      return 24'(base + 24'({vec, 1'b0}));
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // A priority field exists for each source below NUM_SRC outside the top half of the last register
   function automatic logic prioExists(input int j);
      return (j < NUM_SRC) && ((j / 4) < NUM_PRIO_REGS - 1 || (j % 4) < 2);
   endfunction

   logic [NUM_EXT-1:0]  extEdge;             // Synchronised pin edges
   logic [NUM_SRC-1:0]  srcSet;              // All set events this cycle
   logic [NUM_TRAP-1:0] trapSet;             // All trap events this cycle
   logic                addrErr;             // Vector-space fetch or jump
   logic                winValid;            // A candidate beats the CPU level
   logic [3:0]          winLevel;            // Its level
   logic [5:0]          winVec;              // Its vector number
   logic                srcBlocked;          // Nesting disable in force
   logic                disiOn;              // Timed disable in force
   logic                busReq;              // Access present
   logic                busTake;             // Access completes this edge
   logic [4:0]          regIdx;              // Word index of the access
   logic [15:0]         rd16;                // Read view of the addressed word
   int                  wordBase;            // Scratch for multi-word registers

   // Event collection and address error detection
   always_comb begin
      // Peripherals supply ready-made pulses; only pin edges are found here
      for (int e = 0; e < NUM_EXT; e++) begin
         extEdge[e] = ctl_r.extPol[e] ? (ctl_r.extPrev[e] & ~ctl_r.sync2[e])
                                      : (~ctl_r.extPrev[e] & ctl_r.sync2[e]);
      end
      srcSet = srcEvent;
      srcSet[EXT_SRC_0] = srcSet[EXT_SRC_0] | extEdge[0];
      srcSet[EXT_SRC_1] = srcSet[EXT_SRC_1] | extEdge[1];
      srcSet[EXT_SRC_2] = srcSet[EXT_SRC_2] | extEdge[2];
      addrErr = (fetchValid && inVecSpace(fetchAddr)) ||
                (branchValid && inVecSpace(branchTarget));
      trapSet = trapEvent;
      trapSet[ADDR_ERR_TRAP] = trapSet[ADDR_ERR_TRAP] | addrErr;
   end

   // Arbitration over the registered flags
   always_comb begin
      srcBlocked = ctl_r.nestDis && (ctl_r.depth != 4'h0);
      disiOn     = (ctl_r.disiCnt != '0);
      winValid   = 1'b0;
      winLevel   = 4'h0;
      winVec     = 6'h00;
      // Walk downward so an equal level at a lower number replaces the earlier pick
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (ctl_r.flags[i] && ctl_r.enables[i] &&
             ctl_r.prio[i] != 3'h0 &&
             {1'b0, ctl_r.prio[i]} > ctl_r.cpuLevel &&
             !srcBlocked &&
             !(disiOn && ctl_r.prio[i] < TIMED_DISABLE_PASS_LVL) &&
             {1'b0, ctl_r.prio[i]} >= winLevel) begin
            winValid = 1'b1;
            winLevel = {1'b0, ctl_r.prio[i]};
            winVec   = 6'(i + SRC_VEC_BASE);
         end
      end
      // Traps sit above every maskable level and override any source
      for (int t = NUM_TRAP - 1; t >= 0; t--) begin
         if (ctl_r.trapFlags[t] && 4'(TRAP_LEVEL_TOP - 4'(t)) > ctl_r.cpuLevel) begin
            winValid = 1'b1;
            winLevel = 4'(TRAP_LEVEL_TOP - 4'(t));
            winVec   = 6'(t + TRAP_VEC_BASE);
         end
      end
   end

   // Register read view
   always_comb begin
      busReq   = read | write;
      busTake  = busReq & ctl_r.busDone;
      regIdx   = address[6:2];
      rd16     = 16'h0000;
      wordBase = 0;
      if (regIdx < OFS_EN0[6:2]) begin
         // Request flag words; bits above the source count read zero
         wordBase = 16 * int'(regIdx - OFS_FLAGS0[6:2]);
         for (int b = 0; b < 16; b++) begin
            if (wordBase + b < NUM_SRC) rd16[b] = ctl_r.flags[wordBase + b];
         end
      end else if (regIdx < OFS_PRIO0[6:2]) begin
         wordBase = 16 * int'(regIdx - OFS_EN0[6:2]);
         for (int b = 0; b < 16; b++) begin
            if (wordBase + b < NUM_SRC) rd16[b] = ctl_r.enables[wordBase + b];
         end
      end else if (regIdx < OFS_GCTL1[6:2]) begin
         // Nibble n holds its field in bits 2:0, bit 3 reads zero
         wordBase = 4 * int'(regIdx - OFS_PRIO0[6:2]);
         for (int n = 0; n < 4; n++) begin
            if (prioExists(wordBase + n)) rd16[4*n +: 3] = ctl_r.prio[wordBase + n];
         end
      end else if (regIdx == OFS_GCTL1[6:2]) begin
         rd16[NEST_DIS_BIT]   = ctl_r.nestDis;
         rd16[NUM_TRAP-1:0]   = ctl_r.trapFlags;
      end else if (regIdx == OFS_GCTL2[6:2]) begin
         rd16[ALT_SEL_BIT]    = ctl_r.altSel;
         rd16[TIMED_DISABLE_BIT]       = disiOn;
         rd16[NUM_EXT-1:0]    = ctl_r.extPol;
      end else if (regIdx == OFS_CPULVL[6:2]) begin
         rd16[3:0]            = ctl_r.cpuLevel;
      end else if (regIdx == OFS_STATUS[6:2]) begin
         rd16[3:0]            = ctl_r.depth;
         rd16[9:4]            = winVec;
         rd16[15]             = winValid;
      end
   end

   // Next-state logic
   always_comb begin
      int wrBase;                            // Own scratch, the read view keeps wordBase
      wrBase  = 0;
      ctl_nxt = ctl_r;

      // Pin synchronisers and edge history
      ctl_nxt.sync1   = extPin;
      ctl_nxt.sync2   = ctl_r.sync1;
      ctl_nxt.extPrev = ctl_r.sync2;

      // Bus slave: one wait state, read data latched in the first cycle
      ctl_nxt.busDone = busReq & ~ctl_r.busDone;
      if (busReq && !ctl_r.busDone) begin
         ctl_nxt.rdata = {16'h0000, rd16};
      end

      // Software writes land on the edge that ends the access
      if (busTake && write) begin
         if (regIdx < OFS_EN0[6:2]) begin
            wrBase = 16 * int'(regIdx - OFS_FLAGS0[6:2]);
            for (int b = 0; b < 16; b++) begin
               if (wrBase + b < NUM_SRC && byteenable[b / 8])
                  ctl_nxt.flags[wrBase + b] = writedata[b];
            end
         end else if (regIdx < OFS_PRIO0[6:2]) begin
            wrBase = 16 * int'(regIdx - OFS_EN0[6:2]);
            for (int b = 0; b < 16; b++) begin
               if (wrBase + b < NUM_SRC && byteenable[b / 8])
                  ctl_nxt.enables[wrBase + b] = writedata[b];
            end
         end else if (regIdx < OFS_GCTL1[6:2]) begin
            wrBase = 4 * int'(regIdx - OFS_PRIO0[6:2]);
            for (int n = 0; n < 4; n++) begin
               if (prioExists(wrBase + n) && byteenable[n / 2])
                  ctl_nxt.prio[wrBase + n] = writedata[4*n +: 3];
            end
         end else if (regIdx == OFS_GCTL1[6:2]) begin
            if (byteenable[1]) ctl_nxt.nestDis = writedata[NEST_DIS_BIT];
            if (byteenable[0]) ctl_nxt.trapFlags = writedata[NUM_TRAP-1:0];
         end else if (regIdx == OFS_GCTL2[6:2]) begin
            if (byteenable[1]) ctl_nxt.altSel = writedata[ALT_SEL_BIT];
            if (byteenable[0]) ctl_nxt.extPol = writedata[NUM_EXT-1:0];
         end else if (regIdx == OFS_CPULVL[6:2]) begin
            // Level is frozen against software while nesting is disabled
            if (!ctl_r.nestDis && byteenable[0])
               ctl_nxt.cpuLevel = 4'(merge16({12'h000, ctl_r.cpuLevel}, writedata[15:0],
                                             byteenable[1:0]));
         end
      end

      // Hardware sets win over a software clear in the same cycle
      ctl_nxt.flags     = ctl_nxt.flags | srcSet;
      ctl_nxt.trapFlags = ctl_nxt.trapFlags | trapSet;

      // Timed disable counts retired instructions
      if (disiStart) begin
         ctl_nxt.disiCnt = disiCount;
      end else if (instrRetire && disiOn) begin
         ctl_nxt.disiCnt = TIMED_DISABLE_W'(ctl_r.disiCnt - 1'b1);
      end

      // Return restores the level saved by the core
      if (retDone) begin
         ctl_nxt.cpuLevel = retLevel;
         if (ctl_r.depth != 4'h0) ctl_nxt.depth = 4'(ctl_r.depth - 4'h1);
      end

      // Acceptance sequence
      ctl_nxt.pcLoad = 1'b0;
      unique case (ctl_r.st)
         ST_IDLE, ST_OFFER: begin
            if (ctl_r.st == ST_OFFER && irqAck) begin
               // Core took what was shown; raise its level and fetch the vector
               ctl_nxt.cpuLevel = ctl_r.offerLevel;
               if (ctl_r.depth != 4'hF) ctl_nxt.depth = 4'(ctl_r.depth + 4'h1);
               ctl_nxt.st = ST_FETCH;
            end else if (winValid) begin
               // Offer follows the winner each cycle until taken
               ctl_nxt.offerLevel = winLevel;
               ctl_nxt.offerAddr  = vecEntry(ctl_r.altSel, winVec);
               ctl_nxt.st         = ST_OFFER;
            end else begin
               ctl_nxt.st = ST_IDLE;
            end
         end
         ST_FETCH: begin
            if (vecFetchValid) begin
               ctl_nxt.pcLoad  = 1'b1;
               ctl_nxt.pcValue = progData;
               ctl_nxt.st      = ST_IDLE;
            end
         end
         default: ctl_nxt.st = ST_IDLE;
      endcase

      // Branch path of the counter mux; a vector load has precedence
      if (branchValid && !inVecSpace(branchTarget) && !ctl_nxt.pcLoad) begin
         ctl_nxt.pcLoad  = 1'b1;
         ctl_nxt.pcValue = branchTarget;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         ctl_r          <= '0;
         ctl_r.prio     <= {NUM_SRC{RST_PRIO}};
         ctl_r.cpuLevel <= RST_CPULVL;
         ctl_r.st       <= ST_IDLE;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // Outputs
   assign readdata     = ctl_r.rdata;
   assign waitrequest  = busReq & ~ctl_r.busDone;
   assign irqReq       = (ctl_r.st == ST_OFFER);
   assign irqLevel     = ctl_r.offerLevel;
   assign irqVecAddr   = ctl_r.offerAddr;
   assign cpuLevel     = ctl_r.cpuLevel;
   assign timedDisable = disiOn;
   assign vecFetchReq  = (ctl_r.st == ST_FETCH);
   assign vecFetchAddr = ctl_r.offerAddr;
   assign pcLoad       = ctl_r.pcLoad;
   assign pcValue      = ctl_r.pcValue;
endmodule

// [src/intc_pkg.sv]
/*
 * Shared constants for the priority interrupt controller: register byte
 * offsets, field positions, reset values, vector-space layout and the
 * controller's sequencing states.
 * Assumes a 16-bit register view placed in the low half of a 32-bit
 * Avalon-MM data word.
 */
package intc_pkg;
   // Sizes
   localparam int NUM_SRC_DEF   = 24;      // Maskable request sources
   localparam int NUM_TRAP      = 4;       // Processor exception sources
   localparam int NUM_EXT       = 3;       // External request pins
   localparam int TIMED_DISABLE_W_DEF    = 14;      // Timed-disable count width
   localparam int ADDR_W        = 7;       // Byte address width of the slave
   localparam int MAX_SRC       = 46;      // Priority fields the map can hold

   // Source numbers fed by the external pins
   localparam int EXT_SRC_0     = 0;
   localparam int EXT_SRC_1     = 16;
   localparam int EXT_SRC_2     = 23;

   // Register byte offsets
   localparam logic [6:0] OFS_FLAGS0 = 7'h00;
   localparam logic [6:0] OFS_EN0    = 7'h0C;
   localparam logic [6:0] OFS_PRIO0  = 7'h18;
   localparam logic [6:0] OFS_GCTL1  = 7'h48;
   localparam logic [6:0] OFS_GCTL2  = 7'h4C;
   localparam logic [6:0] OFS_CPULVL = 7'h50;
   localparam logic [6:0] OFS_STATUS = 7'h54;
   localparam int         NUM_PRIO_REGS = 12;

   // Field positions
   localparam int NEST_DIS_BIT  = 15;      // Global control first
   localparam int ALT_SEL_BIT   = 15;      // Global control second
   localparam int TIMED_DISABLE_BIT      = 14;      // Global control second, read-only
   localparam int ADDR_ERR_TRAP = 1;       // Trap flag raised on vector-space fetch

   // Reset values
   localparam logic [2:0] RST_PRIO   = 3'h4;
   localparam logic [3:0] RST_CPULVL = 4'h0;

   // Levels and vectors
   localparam logic [3:0] TRAP_LEVEL_TOP = 4'hF;  // Trap t sits at TOP - t
   localparam logic [2:0] TIMED_DISABLE_PASS_LVL  = 3'h7;  // Only this source level passes a timed disable
   localparam int         SRC_VEC_BASE   = 8;     // Vector number of source 0
   localparam int         TRAP_VEC_BASE  = 1;     // Vector number of trap 0
   localparam int         NUM_VECTORS    = 63;
   localparam logic [23:0] VEC_FIRST_ADDR = 24'h00_0004;
   localparam logic [23:0] VEC_LAST_ADDR  = 24'h00_00FE;
   localparam logic [23:0] ALT_BASE_DEF   = 24'h00_0104;
   localparam logic [23:0] VEC_TABLE_SPAN = 24'h00_00FA;  // Last entry minus first

   // Sequencing of one acceptance
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_OFFER = 2'b01,
      ST_FETCH = 2'b10
   } ctl_state_t;
endpackage

// [test/intc_checker_sva.sv]
/*
 * Concurrent checks on the interrupt controller's ports: bus wait state,
 * offer and acceptance, vector fetch and counter load, jump screening.
 * Assumes binding onto the top module; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module intc_checker import intc_pkg::*; #(
   parameter logic [23:0] ALT_BASE = ALT_BASE_DEF
) (
   // Clock, reset and bus
   input wire logic        clk, srst, read, write, waitrequest,
   input wire logic [31:0] readdata,
   // Offer, fetch and counter load
   input wire logic        irqReq, irqAck, vecFetchReq, vecFetchValid, pcLoad,
   input wire logic [3:0]  irqLevel, cpuLevel,
   input wire logic [23:0] irqVecAddr, progData, pcValue, branchTarget,
   input wire logic        branchValid, disiStart, timedDisable,
   input wire logic [13:0] disiCount
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // True for any word of either vector table
   function automatic logic in_space(logic [23:0] a);
      return (a >= VEC_FIRST_ADDR && a <= VEC_LAST_ADDR) ||
             (a >= ALT_BASE && a <= ALT_BASE + VEC_TABLE_SPAN);
   endfunction
   // A vector load outranks a jump on the same edge
   sequence s_accept; irqReq && irqAck; endsequence
   sequence s_vector; vecFetchReq && vecFetchValid; endsequence
   a_bus_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("bus wait state is not exactly one cycle");
   a_read_high: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_offer_above: assert property (irqReq |-> irqLevel > cpuLevel)
      else $error("offer not above cpu level");
   a_accept_fetch: assert property (s_accept |=> vecFetchReq && !irqReq && cpuLevel == $past(irqLevel))
      else $error("acceptance did not start fetch at offered level");
   a_vec_table: assert property (irqReq |-> !irqVecAddr[0] && in_space(irqVecAddr))
      else $error("vector address outside tables");
   a_vec_load: assert property (s_vector |=> pcLoad && pcValue == $past(progData))
      else $error("fetched vector not loaded");
   a_jump_load: assert property (branchValid && !in_space(branchTarget) && !(vecFetchReq && vecFetchValid)
      |=> pcLoad && pcValue == $past(branchTarget))
      else $error("jump outside vector space not loaded");
   a_jump_trap: assert property (branchValid && in_space(branchTarget) && !(vecFetchReq && vecFetchValid)
      |=> !pcLoad)
      else $error("jump into vector space was loaded");
   a_timed_disable_hold: assert property (disiStart && disiCount != 14'h0000 |=> timedDisable)
      else $error("timed disable not raised");
   a_timed_disable_block: assert property (timedDisable && irqReq |-> irqLevel >= 4'h7)
      else $error("low level offered under timed disable");
endmodule

// [test/core_model.sv]
/*
 * Behavioural core: acknowledges offers after a set lag and returns the
 * vector word one cycle after each fetch request.
 * Assumes the controller's clock and reset; lag comes from the bench.
 */
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Offer and fetch
   input  wire logic        irqReq,
   input  wire logic        vecFetchReq,
   input  wire logic [23:0] vecFetchAddr,
   input  wire logic [1:0]  lag,
   output logic             irqAck,
   output logic             vecFetchValid,
   output logic [23:0]      progData
);
   logic [1:0] waitCnt_r;  // Cycles an offer has waited
   // Data toggles when idle so a stale word never looks valid
   always_ff @(posedge clk) begin
      if (srst) begin
         waitCnt_r     <= 2'h0;
         irqAck        <= 1'b0;
         vecFetchValid <= 1'b0;
         progData      <= 24'h00_0000;
      end else begin
         if (irqReq && !irqAck) begin
            waitCnt_r <= waitCnt_r + 2'h1;
            irqAck    <= (waitCnt_r >= lag);
         end else begin
            waitCnt_r <= 2'h0;
            irqAck    <= 1'b0;
         end
         vecFetchValid <= vecFetchReq && !vecFetchValid;
         progData <= (vecFetchReq && !vecFetchValid) ? (24'h40_0000 | vecFetchAddr)
                                                      : ~progData;
      end
   end
endmodule

// [test/priority_interrupt_controller_bench.sv]
/*
 * Self-checking bench: register access over Avalon-MM, acceptance with
 * both tables, nesting lock, jump screening and timed disable.
 * Assumes the checker and core model files are compiled before this one.
 */
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
   import intc_pkg::*;
   logic clk = 0, srst = 1, read = 0, write = 0, retDone = 0, disiStart = 0, instrRetire = 0;
   logic fetchValid = 0, branchValid = 0, waitrequest, irqReq, irqAck, vecFetchReq;
   logic vecFetchValid, pcLoad, timedDisable;
   logic [6:0] address = 0;
   logic [31:0] writedata = 0, readdata, q;
   logic [23:0] srcEvent = 0, fetchAddr = 0, branchTarget = 0, irqVecAddr, vecFetchAddr;
   logic [23:0] progData, pcValue;
   logic [13:0] disiCount = 0;
   logic [3:0] irqLevel, cpuLevel;
   logic [1:0] lag = 1;
   logic [2:0] extPin = 0;
   int n_errors = 0, checks_done = 0, cycles = 0;
   always #2 clk = ~clk;
   priority_interrupt_controller dut_u (.clk, .srst, .address, .read, .write, .writedata,
      .byteenable(4'h3), .readdata, .waitrequest, .srcEvent, .extPin, .trapEvent(4'h0),
      .irqReq, .irqLevel, .irqVecAddr, .irqAck, .retDone, .retLevel(4'h0), .cpuLevel,
      .disiStart, .disiCount, .instrRetire, .timedDisable, .vecFetchReq, .vecFetchAddr,
      .vecFetchValid, .progData, .fetchValid, .fetchAddr, .branchValid, .branchTarget,
      .pcLoad, .pcValue);
   core_model core_u (.clk, .srst, .irqReq, .vecFetchReq, .vecFetchAddr, .lag, .irqAck,
      .vecFetchValid, .progData);
   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // One access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [6:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a; read <= !wr; write <= wr; writedata <= {16'h0000, d};
      do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
      q = readdata; read <= 1'b0; write <= 1'b0;
      if (n >= 50) n_errors++;
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e, input string nm);
      bus(1'b0, a, 16'h0000);
      chk(nm, {16'h0000, e}, q);
   endtask
   // One-cycle pulse on a source, then a settling gap
   task automatic fire();
      @(posedge clk); srcEvent <= 24'h00_0008;
      @(posedge clk); srcEvent <= 24'h00_0000;
      repeat (4) @(posedge clk);
   endtask
   task automatic wait_load(input logic [23:0] e);
      int n;
      n = 0;
      do begin @(negedge clk); n++; end while (pcLoad !== 1'b1 && n < 40);
      if (n >= 40) n_errors++;
      chk("pcValue", {8'h00, e}, {8'h00, pcValue});
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin n_errors++; wrap_up(); end
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_PRIO0, 16'h4444, "prio0");
      rd(OFS_PRIO0 + 7'h2C, 16'h0000, "prio11");
      rd(7'h58, 16'h0000, "unmapped");
      fire();
      rd(OFS_FLAGS0, 16'h0008, "flag disabled");
      chk("irqReq disabled", 32'h0, {31'h0, irqReq});
      bus(1'b1, OFS_FLAGS0, 16'h0000);
      rd(OFS_FLAGS0, 16'h0000, "flag cleared");
      bus(1'b1, OFS_EN0, 16'h0008);
      bus(1'b1, OFS_PRIO0, 16'h0444);
      fire();
      chk("irqReq level zero", 32'h0, {31'h0, irqReq});
      bus(1'b1, OFS_FLAGS0, 16'h0000);
      bus(1'b1, OFS_PRIO0, 16'h5444);
      fire();
      wait_load(24'h40_001A);
      rd(OFS_CPULVL, 16'h0005, "cpu level");
      bus(1'b1, OFS_FLAGS0, 16'h0000);
      @(posedge clk); retDone <= 1'b1;
      @(posedge clk); retDone <= 1'b0;
      bus(1'b1, OFS_GCTL2, 16'h8000);
      lag <= 2'h0;
      fire();
      wait_load(24'h40_011A);
      bus(1'b1, OFS_FLAGS0, 16'h0000);
      bus(1'b1, OFS_GCTL1, 16'h8000);
      bus(1'b1, OFS_CPULVL, 16'h0003);
      rd(OFS_CPULVL, 16'h0005, "cpu level locked");
      bus(1'b1, OFS_PRIO0, 16'h7444);
      fire();
      chk("irqReq nesting", 32'h0, {31'h0, irqReq});
      @(posedge clk); branchValid <= 1'b1; branchTarget <= 24'h00_0010;
      @(posedge clk); branchTarget <= 24'h00_0200;
      @(posedge clk); branchValid <= 1'b0;
      rd(OFS_GCTL1, 16'h8002, "jump trap");
      bus(1'b1, OFS_GCTL1, 16'h8000);
      @(posedge clk); fetchValid <= 1'b1; fetchAddr <= 24'h00_00FE;
      @(posedge clk); fetchValid <= 1'b0;
      rd(OFS_GCTL1, 16'h8002, "fetch trap");
      @(posedge clk); disiStart <= 1'b1; disiCount <= 14'h0003;
      @(posedge clk); disiStart <= 1'b0;
      rd(OFS_GCTL2, 16'hC000, "timed disable on");
      // Level 7 still passes a timed disable, level 5 waits for it to end
      bus(1'b1, OFS_GCTL1, 16'h0000);
      bus(1'b1, OFS_CPULVL, 16'h0000);
      wait_load(24'h40_011A);
      bus(1'b1, OFS_FLAGS0, 16'h0000);
      bus(1'b1, OFS_PRIO0, 16'h5444);
      bus(1'b1, OFS_CPULVL, 16'h0000);
      fire();
      chk("irqReq timed disable", 32'h0, {31'h0, irqReq});
      @(posedge clk); instrRetire <= 1'b1;
      repeat (3) @(posedge clk);
      instrRetire <= 1'b0;
      wait_load(24'h40_011A);
      rd(OFS_GCTL2, 16'h8000, "timed disable off");
      extPin <= 3'h1;
      repeat (6) @(posedge clk);
      rd(OFS_FLAGS0, 16'h0009, "pin edge");
      wrap_up();
   end
endmodule
bind priority_interrupt_controller intc_checker #(.ALT_BASE(ALT_BASE)) chk_u (.clk, .srst,
   .read, .write, .waitrequest, .readdata, .irqReq, .irqAck, .vecFetchReq, .vecFetchValid,
   .pcLoad, .irqLevel, .cpuLevel, .irqVecAddr, .progData, .pcValue, .branchTarget,
   .branchValid, .disiStart, .timedDisable, .disiCount);
